//--- shared/tcc_defs.svh
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// register word addresses on the plain register port
`define TCC_ADDR_CTL0 3'h0
`define TCC_ADDR_CTL1 3'h1
`define TCC_ADDR_CTL2 3'h2
`define TCC_ADDR_STAT 3'h3
`define TCC_ADDR_VREF 3'h4
`define TCC_ADDR_IRQ_STAT 3'h5
`define TCC_ADDR_IRQ_MASK 3'h6

// comparator_control fields
`define TCC_CTL_ON 15
`define TCC_CTL_OPE 14
`define TCC_CTL_POL 13
`define TCC_CTL_EVT 9
`define TCC_CTL_OUT 8
`define TCC_CTL_EDGE_LSB 6
`define TCC_CTL_NONINV 4
`define TCC_CTL_INV_LSB 0
`define TCC_CTL_WMASK 16'hE0D3

// comparator_status fields
`define TCC_STAT_IDLE 15
`define TCC_STAT_EVT_LSB 8
`define TCC_STAT_OUT_LSB 0

// reference_level_control fields
`define TCC_VREF_POSREF 10
`define TCC_VREF_SRC_LSB 8
`define TCC_VREF_PWR 7
`define TCC_VREF_PINDRV 6
`define TCC_VREF_SUPPLY 5
`define TCC_VREF_LEVEL_LSB 0
`define TCC_VREF_WMASK 16'h07FF

// reset values
`define TCC_RST_CTL 16'h0000
`define TCC_RST_VREF 16'h0000
`define TCC_RST_WORD 16'h0000

`endif

//--- shared/tcc_pkg.sv
package tcc_pkg;

    typedef enum logic [1:0] {
        TCC_EDGE_OFF,
        TCC_EDGE_RISE,
        TCC_EDGE_FALL,
        TCC_EDGE_ANY
    } tcc_edge_t;

    typedef struct packed {
        logic active;
        logic result;
        logic pin;
        logic pin_oe;
        logic event_pulse;
    } tcc_chan_state_t;

    typedef struct packed {
        logic [2:0][15:0] ctl;
        logic [2:0] evt_flag;
        logic [2:0] cmp_run;
        logic idle_stop;
        logic [15:0] vref;
        logic ref_drive;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic irq;
        logic [15:0] rd_data;
    } tcc_state_t;

endpackage : tcc_pkg

//--- src/tcc_cmp_chan.sv
`include "tcc_defs.svh"

module tcc_cmp_chan (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // analog result and configuration
    input wire logic raw_result,
    input wire logic comparator_on,
    input wire logic output_polarity,
    input wire logic output_to_pin_enable,
    input wire logic [1:0] event_edge_select,
    input wire logic idle_mode,
    input wire logic idle_stop,
    input wire logic sticky_event_flag,
    // results
    output logic comparator_result,
    output logic result_pin,
    output logic result_pin_oe,
    output logic event_pulse
);

    tcc_pkg::tcc_chan_state_t q;
    tcc_pkg::tcc_chan_state_t n;
    tcc_pkg::tcc_edge_t edge_sel;
    logic active;
    logic hit;

    assign edge_sel = tcc_pkg::tcc_edge_t'(event_edge_select);

    always_comb begin
        n = q;
        active = comparator_on & ~(idle_stop & idle_mode);
        n.active = active;
        // polarity applies before the flag, the pin and the edge check
        n.result = active & (raw_result ^ output_polarity);
        n.pin = n.result;
        n.pin_oe = output_to_pin_enable & active;
        unique case (edge_sel)
            tcc_pkg::TCC_EDGE_OFF: hit = 1'b0;
            tcc_pkg::TCC_EDGE_RISE: hit = n.result & ~q.result;
            tcc_pkg::TCC_EDGE_FALL: hit = ~n.result & q.result;
            tcc_pkg::TCC_EDGE_ANY: hit = n.result ^ q.result;
        endcase
        // a pulse still in flight counts as a set flag
        n.event_pulse = active & q.active & hit
            & ~sticky_event_flag & ~q.event_pulse;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign comparator_result = q.result;
    assign result_pin = q.pin;
    assign result_pin_oe = q.pin_oe;
    assign event_pulse = q.event_pulse;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_armed_rise;
        q.active && !q.result && !q.event_pulse && !sticky_event_flag
            && edge_sel == tcc_pkg::TCC_EDGE_RISE;
    endsequence

    sequence s_risen;
        q.active && q.result;
    endsequence

    a_rise_event: assert property (
        s_armed_rise ##1 s_risen |-> event_pulse)
        else $error("rising edge gave no event");

    a_flag_blocks: assert property (
        sticky_event_flag |=> !event_pulse)
        else $error("event while flag set");

    a_off_quiet: assert property (!comparator_on |=>
        !comparator_result && !result_pin_oe && !event_pulse)
        else $error("disabled comparator active");

    a_pin_drive: assert property (
        output_to_pin_enable && comparator_on && !idle_mode
        |=> result_pin_oe && result_pin == comparator_result)
        else $error("result pin not driven");

    a_polarity: assert property (comparator_on && !idle_mode |=>
        comparator_result == ($past(raw_result) ^ $past(output_polarity)))
        else $error("polarity wrong");

endmodule : tcc_cmp_chan

//--- src/tcc_comparator_ctrl.sv
// Added by the designer: the register offsets and the address-and-strobe port.
`include "tcc_defs.svh"

module tcc_comparator_ctrl #(
    parameter int NUM_CMP = 3,
    parameter int LEVEL_W = 5
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [2:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rd_data,
    // system state and analog results
    input wire logic idle_mode,
    input wire logic [NUM_CMP-1:0] raw_result,
    // comparator analog controls
    output logic [NUM_CMP-1:0] comparator_on,
    output logic [NUM_CMP-1:0] noninverting_input_select,
    output logic [2*NUM_CMP-1:0] inverting_input_select,
    // result pins
    output logic [NUM_CMP-1:0] result_pin,
    output logic [NUM_CMP-1:0] result_pin_oe,
    // reference generator controls
    output logic reference_power_on,
    output logic reference_pin_drive,
    output logic ladder_supply_select,
    output logic [LEVEL_W-1:0] ladder_level_select,
    output logic [1:0] reference_source_field,
    output logic positive_reference_select,
    // interrupt
    output logic irq
);

    if (NUM_CMP != 3) begin : g_bad_num
        $error("status layout serves exactly three comparators");
    end
    if (LEVEL_W != 5) begin : g_bad_level
        $error("level field is five bits wide");
    end

    tcc_pkg::tcc_state_t q;
    tcc_pkg::tcc_state_t n;
    logic [2:0] evt_pulse;
    logic [2:0] result;
    logic [2:0] pin;
    logic [2:0] pin_oe;
    logic [2:0] irq_clr;
    logic [15:0] ctl_view;

    // word addresses 0..2 select a comparator_control register
    function automatic logic is_ctl(input logic [2:0] a);
        return a <= `TCC_ADDR_CTL2;
    endfunction : is_ctl

    function automatic logic [1:0] ctl_index(input logic [2:0] a);
        return a[1:0];
    endfunction : ctl_index

    ////////////////////////////////////////////////////////////////////////
    // per-comparator datapath

    for (genvar i = 0; i < 3; i++) begin : g_chan
        tcc_cmp_chan u_chan (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .raw_result(raw_result[i]),
            .comparator_on(q.ctl[i][`TCC_CTL_ON]),
            .output_polarity(q.ctl[i][`TCC_CTL_POL]),
            .output_to_pin_enable(q.ctl[i][`TCC_CTL_OPE]),
            .event_edge_select(q.ctl[i][`TCC_CTL_EDGE_LSB +: 2]),
            .idle_mode(idle_mode),
            .idle_stop(q.idle_stop),
            .sticky_event_flag(q.evt_flag[i]),
            .comparator_result(result[i]),
            .result_pin(pin[i]),
            .result_pin_oe(pin_oe[i]),
            .event_pulse(evt_pulse[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // register file and interrupt

    always_comb begin
        n = q;
        irq_clr = 3'h0;
        ctl_view = `TCC_RST_WORD;

        for (int i = 0; i < 3; i++) begin
            if (wr_en && is_ctl(addr) && ctl_index(addr) == 2'(i)) begin
                n.ctl[i] = wr_data & `TCC_CTL_WMASK;
                n.evt_flag[i] = wr_data[`TCC_CTL_EVT];
            end
            // hardware set wins over a software clear in the same cycle
            if (evt_pulse[i]) begin
                n.evt_flag[i] = 1'b1;
            end
            n.cmp_run[i] = n.ctl[i][`TCC_CTL_ON]
                & ~(n.idle_stop & idle_mode);
        end

        if (wr_en && addr == `TCC_ADDR_STAT) begin
            n.idle_stop = wr_data[`TCC_STAT_IDLE];
        end
        for (int i = 0; i < 3; i++) begin
            n.cmp_run[i] = n.ctl[i][`TCC_CTL_ON]
                & ~(n.idle_stop & idle_mode);
        end

        if (wr_en && addr == `TCC_ADDR_VREF) begin
            n.vref = wr_data & `TCC_VREF_WMASK;
        end
        // registered so the pin drive output comes from a flip-flop
        n.ref_drive = n.vref[`TCC_VREF_PINDRV]
            & n.vref[`TCC_VREF_PWR];

        if (wr_en && addr == `TCC_ADDR_IRQ_MASK) begin
            n.irq_mask = wr_data[2:0];
        end
        if (wr_en && addr == `TCC_ADDR_IRQ_STAT) begin
            irq_clr = wr_data[2:0];
        end
        n.irq_stat = (q.irq_stat & ~irq_clr) | evt_pulse;
        n.irq = |(n.irq_stat & n.irq_mask);

        // read data stand only in the cycle after the read strobe
        n.rd_data = `TCC_RST_WORD;
        if (rd_en) begin
            if (is_ctl(addr) && addr != `TCC_ADDR_STAT) begin
                ctl_view = q.ctl[ctl_index(addr)];
                ctl_view[`TCC_CTL_EVT] = q.evt_flag[ctl_index(addr)];
                ctl_view[`TCC_CTL_OUT] = result[ctl_index(addr)];
                n.rd_data = ctl_view;
            end else if (addr == `TCC_ADDR_STAT) begin
                n.rd_data[`TCC_STAT_IDLE] = q.idle_stop;
                n.rd_data[`TCC_STAT_EVT_LSB +: 3] = q.evt_flag;
                n.rd_data[`TCC_STAT_OUT_LSB +: 3] = result;
            end else if (addr == `TCC_ADDR_VREF) begin
                n.rd_data = q.vref;
            end else if (addr == `TCC_ADDR_IRQ_STAT) begin
                n.rd_data[2:0] = q.irq_stat;
            end else if (addr == `TCC_ADDR_IRQ_MASK) begin
                n.rd_data[2:0] = q.irq_mask;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all taken from flip-flops

    assign rd_data = q.rd_data;
    assign irq = q.irq;
    assign comparator_on = q.cmp_run;
    assign result_pin = pin;
    assign result_pin_oe = pin_oe;

    for (genvar i = 0; i < 3; i++) begin : g_mux
        // analog side routes pin A or internal reference
        assign noninverting_input_select[i] =
            q.ctl[i][`TCC_CTL_NONINV];
        // code 11 makes the analog mux follow reference_source_field
        assign inverting_input_select[2*i +: 2] =
            q.ctl[i][`TCC_CTL_INV_LSB +: 2];
    end

    assign reference_power_on = q.vref[`TCC_VREF_PWR];
    // gated by power so a dead ladder never drives the pin
    assign reference_pin_drive = q.ref_drive;
    assign ladder_supply_select = q.vref[`TCC_VREF_SUPPLY];
    assign ladder_level_select =
        q.vref[`TCC_VREF_LEVEL_LSB +: LEVEL_W];
    // reserved codes pass through unchanged; the analog side ignores them
    assign reference_source_field =
        q.vref[`TCC_VREF_SRC_LSB +: 2];
    assign positive_reference_select = q.vref[`TCC_VREF_POSREF];

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_stat_rd;
        rd_en && addr == `TCC_ADDR_STAT;
    endsequence

    sequence s_vref_wr;
        wr_en && addr == `TCC_ADDR_VREF;
    endsequence

    sequence s_ctl1_wr;
        wr_en && addr == `TCC_ADDR_CTL1;
    endsequence

    for (genvar i = 0; i < 3; i++) begin : g_chk
        // a write to this comparator's control word
        sequence s_ctl_wr;
            wr_en && addr == 3'(i);
        endsequence

        // a software clear that no hardware set overrides
        sequence s_flag_clr;
            wr_en && addr == 3'(i) && !wr_data[`TCC_CTL_EVT]
                && !evt_pulse[i];
        endsequence

        a_flag_on_event: assert property (
            evt_pulse[i] |=> q.evt_flag[i])
            else $error("event did not set flag");

        a_flag_sticky: assert property (q.evt_flag[i]
            && !(wr_en && addr == 3'(i) && !wr_data[`TCC_CTL_EVT])
            |=> q.evt_flag[i])
            else $error("flag dropped without clear");

        a_flag_clear: assert property (s_flag_clr |=>
            !q.evt_flag[i])
            else $error("software clear lost");

        a_noninv_sel: assert property (s_ctl_wr |=>
            noninverting_input_select[i]
            == $past(wr_data[`TCC_CTL_NONINV]))
            else $error("noninverting select not stored");

        a_chan_sel: assert property (s_ctl_wr |=>
            inverting_input_select[2*i +: 2]
            == $past(wr_data[`TCC_CTL_INV_LSB +: 2]))
            else $error("inverting select not stored");

        a_on_follow: assert property (
            s_ctl_wr ##0 !idle_mode
            |=> comparator_on[i] == $past(wr_data[`TCC_CTL_ON]))
            else $error("on bit not followed");

        a_idle_keeps: assert property (!q.idle_stop && !wr_en
            |=> comparator_on[i] == q.ctl[i][`TCC_CTL_ON])
            else $error("comparator stopped with idle stop clear");

        a_irq_set: assert property (evt_pulse[i] |=> q.irq_stat[i])
            else $error("event did not reach interrupt status");

        a_irq_clear: assert property (wr_en
            && addr == `TCC_ADDR_IRQ_STAT && wr_data[i] && !evt_pulse[i]
            |=> !q.irq_stat[i])
            else $error("interrupt status not cleared");
    end

    a_irq_level: assert property (irq == |(q.irq_stat & q.irq_mask))
        else $error("interrupt level wrong");

    a_stat_read: assert property (s_stat_rd |=>
        rd_data[`TCC_STAT_EVT_LSB +: 3] == $past(q.evt_flag)
        && rd_data[`TCC_STAT_OUT_LSB +: 3] == $past(result))
        else $error("status read mismatch");

    a_rd_quiet: assert property (!rd_en |=> rd_data == `TCC_RST_WORD)
        else $error("read data stood longer than one cycle");

    a_idle_halt: assert property (q.idle_stop && idle_mode
        && !(wr_en && addr == `TCC_ADDR_STAT) |=> comparator_on == 3'h0)
        else $error("comparator ran in idle");

    a_level_write: assert property (s_vref_wr |=>
        ladder_level_select == $past(wr_data[4:0])
        && ladder_supply_select == $past(wr_data[`TCC_VREF_SUPPLY]))
        else $error("reference level not stored");

    a_src_field: assert property (s_vref_wr |=>
        reference_source_field == $past(wr_data[`TCC_VREF_SRC_LSB +: 2])
        && positive_reference_select == $past(wr_data[`TCC_VREF_POSREF]))
        else $error("reference source not stored");

    a_ref_power: assert property (s_vref_wr |=>
        reference_power_on == $past(wr_data[`TCC_VREF_PWR])
        && reference_pin_drive == ($past(wr_data[`TCC_VREF_PINDRV])
        && $past(wr_data[`TCC_VREF_PWR])))
        else $error("reference power or pin drive not stored");

    a_ref_pin_power: assert property (reference_pin_drive |->
        reference_power_on)
        else $error("reference pin driven while off");

    a_inv_select: assert property (s_ctl1_wr |=>
        inverting_input_select[3:2] == $past(wr_data[1:0])
        && noninverting_input_select[1] == $past(wr_data[4]))
        else $error("input select not stored");

endmodule : tcc_comparator_ctrl

//--- tb/tb.sv
`include "tcc_defs.svh"

`define CHK(a, b) begin \
    comparisons++; \
    if ((a) !== (b)) begin \
        n_fail++; \
        $display("unexpected %0t: got %h want %h", $time, (a), (b)); \
    end \
end

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk;
    logic rst_n;
    logic [2:0] addr;
    logic [15:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [15:0] rd_data;
    logic idle_mode;
    logic [2:0] raw_result;
    logic [2:0] comparator_on;
    logic [2:0] noninverting_input_select;
    logic [5:0] inverting_input_select;
    logic [2:0] result_pin;
    logic [2:0] result_pin_oe;
    logic reference_power_on;
    logic reference_pin_drive;
    logic ladder_supply_select;
    logic [4:0] ladder_level_select;
    logic [1:0] reference_source_field;
    logic positive_reference_select;
    logic irq;
    int n_fail;
    int comparisons;
    int cyc = 0;

    tcc_comparator_ctrl i_tcc_comparator_ctrl (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .addr(addr),
        .wr_data(wr_data),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rd_data(rd_data),
        .idle_mode(idle_mode),
        .raw_result(raw_result),
        .comparator_on(comparator_on),
        .noninverting_input_select(noninverting_input_select),
        .inverting_input_select(inverting_input_select),
        .result_pin(result_pin),
        .result_pin_oe(result_pin_oe),
        .reference_power_on(reference_power_on),
        .reference_pin_drive(reference_pin_drive),
        .ladder_supply_select(ladder_supply_select),
        .ladder_level_select(ladder_level_select),
        .reference_source_field(reference_source_field),
        .positive_reference_select(positive_reference_select),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        // data stand only in the cycle after the strobe
        @(negedge core_clk);
        d = rd_data;
    endtask : rd

    task automatic set_raw(input int i, input logic v);
        @(posedge core_clk);
        raw_result[i] <= v;
    endtask : set_raw

    // long enough for result, event and flag stages to land
    task automatic settle;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle

    // expected readback of a comparator_control write with the flag clear
    function automatic logic [15:0] exp_ctl(input logic [15:0] d);
        return d & `TCC_CTL_WMASK;
    endfunction : exp_ctl

    // rising counts for edge codes 01 and 11, falling for 10 and 11
    function automatic logic exp_evt(input int m, input logic rising);
        return rising ? (m == 1 || m == 3) : (m == 2 || m == 3);
    endfunction : exp_evt

    task automatic conclude;
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] d;
        logic [15:0] v;
        logic p;
        logic r;
        logic er;
        logic ef;
        rst_n = 1'b0;
        addr = 3'h0;
        wr_data = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        idle_mode = 1'b0;
        raw_result = 3'h0;
        n_fail = 0;
        comparisons = 0;
        void'($urandom(32'hB8ECACBF));
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        // reset values, unmapped address ignores writes
        wr(3'h7, 16'hFFFF);
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), v);
            `CHK(v, 16'h0000)
        end
        // configuration fields with the comparator kept off
        for (int i = 0; i < 3; i++) begin
            for (int k = 0; k < 4; k++) begin
                d = 16'($urandom) & 16'h7DFF;
                d[1:0] = 2'(k);
                wr(3'(i), d);
                rd(3'(i), v);
                `CHK(v, exp_ctl(d))
                settle();
                `CHK(noninverting_input_select[i], d[4])
                `CHK(inverting_input_select[2*i+:2], d[1:0])
                `CHK(comparator_on[i], 1'b0)
                `CHK(result_pin_oe[i], 1'b0)
            end
        end
        // reference fields, corners first
        for (int k = 0; k < 10; k++) begin
            d = (k == 0) ? 16'h0000 : (k == 1) ? 16'hFFFF : 16'($urandom);
            wr(`TCC_ADDR_VREF, d);
            rd(`TCC_ADDR_VREF, v);
            `CHK(v, d & `TCC_VREF_WMASK)
            `CHK(ladder_level_select, d[4:0])
            `CHK(ladder_supply_select, d[5])
            `CHK(reference_source_field, d[9:8])
            `CHK(positive_reference_select, d[10])
            `CHK(reference_power_on, d[7])
            `CHK(reference_pin_drive, d[6] & d[7])
        end
        // polarity and pin routing, events off
        for (int i = 0; i < 3; i++) begin
            p = 1'($urandom);
            r = 1'($urandom);
            set_raw(i, r);
            wr(3'(i), 16'hC000 | (16'(p) << 13));
            settle();
            `CHK(comparator_on[i], 1'b1)
            `CHK(result_pin_oe[i], 1'b1)
            `CHK(result_pin[i], r ^ p)
            rd(`TCC_ADDR_STAT, v);
            `CHK(v[i], r ^ p)
            rd(3'(i), v);
            `CHK(v[8], r ^ p)
            wr(3'(i), 16'h4000);
            settle();
            `CHK(result_pin_oe[i], 1'b0)
            `CHK(comparator_on[i], 1'b0)
        end
        // every edge mode on every comparator, sticky blocking
        for (int i = 0; i < 3; i++) begin
            for (int m = 0; m < 4; m++) begin
                er = exp_evt(m, 1'b1);
                ef = exp_evt(m, 1'b0);
                d = 16'h8000 | (16'(m) << 6);
                set_raw(i, 1'b0);
                wr(3'(i), d);
                wr(`TCC_ADDR_IRQ_STAT, 16'h0007);
                wr(`TCC_ADDR_IRQ_MASK, 16'h0001 << i);
                settle();
                set_raw(i, 1'b1);
                settle();
                rd(3'(i), v);
                `CHK(v[9], er)
                rd(`TCC_ADDR_STAT, v);
                `CHK(v[8+i], er)
                `CHK(irq, er)
                wr(3'(i), d);
                wr(`TCC_ADDR_IRQ_STAT, 16'h0007);
                set_raw(i, 1'b0);
                settle();
                rd(3'(i), v);
                `CHK(v[9], ef)
                // flag left set in edge modes 10 and 11: the next edge must not count
                wr(`TCC_ADDR_IRQ_STAT, 16'h0007);
                set_raw(i, 1'b1);
                settle();
                rd(`TCC_ADDR_IRQ_STAT, v);
                `CHK(v[i], er & !ef)
                wr(`TCC_ADDR_IRQ_MASK, 16'h0000);
                settle();
                `CHK(irq, 1'b0)
                wr(3'(i), 16'h0000);
            end
        end
        // inverted polarity: a falling input is a rising result
        set_raw(0, 1'b1);
        wr(3'h0, 16'hA040);
        settle();
        set_raw(0, 1'b0);
        settle();
        rd(3'h0, v);
        `CHK(v[9], 1'b1)
        `CHK(v[8], 1'b1)
        wr(3'h0, 16'h0000);
        // idle halt on and off
        set_raw(0, 1'b0);
        wr(`TCC_ADDR_STAT, 16'h8000);
        wr(3'h0, 16'h8000);
        @(posedge core_clk);
        idle_mode <= 1'b1;
        settle();
        `CHK(comparator_on[0], 1'b0)
        rd(`TCC_ADDR_STAT, v);
        `CHK(v, 16'h8000)
        wr(`TCC_ADDR_STAT, 16'h0000);
        settle();
        `CHK(comparator_on[0], 1'b1)
        conclude();
    end
endmodule : tb
